/* sr_ctrl_defs.svh */
// constants for the self refresh control block
// assumes inclusion by the package and the main module only
`ifndef SR_CTRL_DEFS_SVH
`define SR_CTRL_DEFS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OFS_MODE        8'h00
`define OFS_STATUS      8'h04
`define OFS_TIMING      8'h08
`define OFS_REFCNT      8'h0c
// ----------------------------------------
// mode register fields
// ----------------------------------------
`define MODE_RATE_LO    0
`define MODE_RATE_HI    1
`define MODE_ABORT_BIT  2
`define MODE_DLL_ON_BIT 3
`define MODE_PARK_BIT   4
`define MODE_PAR_BIT    5
`define MODE_RESET      8'h08
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_PS   4000
`define TRFC_PS         350000
`define TXS_EXTRA_PS    10000
`define TXS_CYC         (((`TRFC_PS + `TXS_EXTRA_PS) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define TXSFAST_DEF     16'd60
`define TXSABORT_DEF    16'd60
`define TXSDLL_DEF      16'd768
`define TCKE_DEF        16'd2
`define REF_INTERVAL    16'd1950
`endif

/* sr_ctrl_pkg.sv */
// types for the self refresh control block
// assumes sr_ctrl_defs.svh is on the include path
package sr_ctrl_pkg;
  `include "sr_ctrl_defs.svh"
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SELF   = 4'b0010,
    ST_EXIT   = 4'b0100,
    ST_NOPWIN = 4'b1000
  } sr_state_t;
  typedef enum logic [1:0] {
    RATE_NORMAL  = 2'b00,
    RATE_REDUCED = 2'b01,
    RATE_EXTEND  = 2'b10,
    RATE_AUTO    = 2'b11
  } rate_t;
endpackage : sr_ctrl_pkg

/* sr_cmd_decode.sv */
// command decoder for the ddr command pins
// assumes pins already registered on the rising clock edge
module sr_cmd_decode (
  input  wire logic i_cs_n,
  input  wire logic i_act_n,
  input  wire logic i_ras_n,
  input  wire logic i_cas_n,
  input  wire logic i_we_n,
  input  wire logic i_cke,
  output logic      o_sre,
  output logic      o_ref,
  output logic      o_des,
  output logic      o_nop
);
  assign o_sre = !i_cs_n && i_act_n && !i_ras_n && !i_cas_n && i_we_n && !i_cke;
  assign o_ref = !i_cs_n && i_act_n && !i_ras_n && !i_cas_n && i_we_n && i_cke;
  assign o_des = i_cs_n;
  assign o_nop = !i_cs_n && i_act_n && i_ras_n && i_cas_n && i_we_n;
endmodule : sr_cmd_decode

/* sr_down_counter.sv */
// loadable down counter with a done flag
// assumes one synchronous active high reset
module sr_down_counter (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_load,
  input  wire logic [15:0] i_value,
  output logic             o_done
);
  logic [15:0] cnt_reg;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cnt_reg <= 16'h0000;
    end else if (i_load) begin
      cnt_reg <= i_value;
    end else if (cnt_reg != 16'h0000) begin
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end
  assign o_done = (cnt_reg == 16'h0000);
endmodule : sr_down_counter

/* sr_ctrl.sv */
// self refresh entry and exit control inside the dram
// assumes synchronous pins on i_ref_clk and a classic wishbone master
// How it works
// - entry decoded: cs, ras, cas, cke low with we and act high.
// - termination high impedance in self refresh; park restored during dll window.
// - dll off at entry; re-enabled with reset at exit.
// - in self refresh with cke low the state follows only cke and reset; sre before the first internal refresh sets the error.
// - internal refresh starts within tcke, own timer, internal clock gated.
// - exit is cke registered high with deselect.
// - txs equals trfc plus 10 ns.
// - abort mode cancels refresh, no counter advance, txs_abort applies.
// - two rate bits: normal, reduced, extended, automatic.
// - nop exit allowed without parity; fast and abort timings unused.
`include "sr_ctrl_defs.svh"
module sr_ctrl
  import sr_ctrl_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_cke,
  input  wire logic        i_cs_n,
  input  wire logic        i_act_n,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  input  wire logic        i_odt,
  input  wire logic [1:0]  i_temp_zone,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  output logic             o_in_self_refresh,
  output logic             o_int_clk_en,
  output logic             o_int_refresh,
  output logic             o_dll_enable,
  output logic             o_dll_reset,
  output logic             o_rtt_park_on,
  output logic             o_odt_enable,
  output logic             o_ok_fast,
  output logic             o_ok_nodll,
  output logic             o_ok_dll,
  output logic             o_proto_error
);
  import sr_ctrl_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  sr_state_t   state_reg, state_next;
  logic [7:0]  mode_reg;
  logic [15:0] txsdll_reg;
  logic [15:0] refcnt_reg;
  logic [15:0] ref_tmr_reg;
  logic        first_ref_reg;
  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic        err_reg;
  logic        need_ref_reg;
  logic        ref_busy_reg;
  logic [1:0]  rate_reg;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  logic dec_sre;
  logic dec_ref;
  logic dec_des;
  logic dec_nop;
  sr_cmd_decode u_dec (
    .i_cs_n  (i_cs_n),
    .i_act_n (i_act_n),
    .i_ras_n (i_ras_n),
    .i_cas_n (i_cas_n),
    .i_we_n  (i_we_n),
    .i_cke   (i_cke),
    .o_sre   (dec_sre),
    .o_ref   (dec_ref),
    .o_des   (dec_des),
    .o_nop   (dec_nop)
  );

  wire st_idle   = (state_reg == ST_IDLE);
  wire st_self   = (state_reg == ST_SELF);
  wire st_exit   = (state_reg == ST_EXIT);
  wire st_nopwin = (state_reg == ST_NOPWIN);
  wire abort_on  = mode_reg[`MODE_ABORT_BIT];
  wire dll_on    = mode_reg[`MODE_DLL_ON_BIT];
  wire park_on   = mode_reg[`MODE_PARK_BIT];
  wire par_on    = mode_reg[`MODE_PAR_BIT];

  wire enter_sr  = !st_self && dec_sre && !(need_ref_reg && !st_idle);
  wire nop_exit  = dec_nop && !par_on;
  wire exit_sr   = st_self && i_cke && (dec_des || nop_exit);
  wire wb_req    = i_wb_cyc && i_wb_stb && !ack_reg;
  wire wb_wr     = wb_req && i_wb_we;

  // ----------------------------------------
  // exit timers
  // ----------------------------------------
  logic done_fast;
  logic done_xs;
  logic done_dll;
  logic done_nop;
  wire [15:0] txs_val  = (abort_on && !nop_exit) ? `TXSABORT_DEF : 16'(`TXS_CYC);
  wire [15:0] fast_val = nop_exit ? 16'(`TXS_CYC) : `TXSFAST_DEF;

  sr_down_counter u_fast (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_load    (exit_sr),
    .i_value   (fast_val),
    .o_done    (done_fast)
  );
  sr_down_counter u_xs (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_load    (exit_sr),
    .i_value   (txs_val),
    .o_done    (done_xs)
  );
  sr_down_counter u_dll (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_load    (exit_sr),
    .i_value   (txsdll_reg),
    .o_done    (done_dll)
  );
  sr_down_counter u_nop (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_load    (exit_sr && nop_exit),
    .i_value   (`TCKE_DEF),
    .o_done    (done_nop)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (enter_sr) begin
          state_next = ST_SELF;
        end
      end
      ST_SELF: begin
        if (exit_sr) begin
          state_next = nop_exit ? ST_NOPWIN : ST_EXIT;
        end
      end
      ST_NOPWIN: begin
        if (done_nop) begin
          state_next = ST_EXIT;
        end
      end
      ST_EXIT: begin
        if (enter_sr) begin
          state_next = ST_SELF;
        end else if (done_dll && done_xs) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // protocol watch on the controller side
  // ----------------------------------------
  wire early_re  = enter_sr && (st_exit || st_nopwin) && (!done_xs || need_ref_reg);
  wire bad_des   = st_exit && !done_xs && !dec_des && !dec_sre;
  wire bad_cke   = st_exit && !done_dll && !i_cke && !dec_sre;
  wire bad_odt   = st_exit && dll_on && !done_dll && i_odt;
  wire bad_nop   = st_nopwin && !dec_nop;
  wire bad_first = st_self && !i_cke && !first_ref_reg && dec_sre;

  // ----------------------------------------
  // internal refresh timer
  // ----------------------------------------
  wire ref_tick = st_self && (ref_tmr_reg == 16'h0000);
  wire [15:0] ref_reload = (rate_reg == RATE_REDUCED) ? (`REF_INTERVAL << 1) :
                           (rate_reg == RATE_EXTEND)  ? (`REF_INTERVAL >> 1) :
                           (rate_reg == RATE_AUTO)    ? (`REF_INTERVAL >> i_temp_zone) :
                           `REF_INTERVAL;
  wire abort_cut = exit_sr && abort_on && !nop_exit && ref_busy_reg;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || !st_self) begin
      ref_tmr_reg   <= `TCKE_DEF - 16'h0001;
      first_ref_reg <= 1'b0;
    end else if (ref_tick) begin
      ref_tmr_reg   <= ref_reload;
      first_ref_reg <= 1'b1;
    end else begin
      ref_tmr_reg   <= ref_tmr_reg - 16'h0001;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      refcnt_reg   <= 16'h0000;
      ref_busy_reg <= 1'b0;
    end else if (abort_cut) begin
      ref_busy_reg <= 1'b0;
    end else if (ref_tick) begin
      ref_busy_reg <= 1'b1;
    end else if (ref_busy_reg) begin
      refcnt_reg   <= refcnt_reg + 16'h0001;
      ref_busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      need_ref_reg <= 1'b0;
    end else if (exit_sr) begin
      need_ref_reg <= 1'b1;
    end else if (dec_ref && done_xs) begin
      need_ref_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rate_reg <= RATE_NORMAL;
    end else if (enter_sr) begin
      rate_reg <= rate_t'(mode_reg[`MODE_RATE_HI:`MODE_RATE_LO]);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      err_reg <= 1'b0;
    end else if (early_re || bad_des || bad_cke || bad_odt || bad_nop || bad_first) begin
      err_reg <= 1'b1;
    end else if (wb_wr && i_wb_adr == `OFS_STATUS && i_wb_dat[8]) begin
      err_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  wire sel_mode   = (i_wb_adr == `OFS_MODE);
  wire sel_status = (i_wb_adr == `OFS_STATUS);
  wire sel_timing = (i_wb_adr == `OFS_TIMING);
  wire sel_refcnt = (i_wb_adr == `OFS_REFCNT);
  wire [31:0] status_word = {23'h000000, err_reg, need_ref_reg, done_dll, done_xs, done_fast,
                             state_reg};
  wire [31:0] rd_mux = sel_mode   ? {24'h000000, mode_reg} :
                       sel_status ? status_word :
                       sel_timing ? {16'h0000, txsdll_reg} :
                       sel_refcnt ? {16'h0000, refcnt_reg} : 32'h00000000;
  wire mode_wr_ok = !st_self || (mode_reg[`MODE_RATE_HI:`MODE_RATE_LO] == RATE_AUTO);

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h00000000;
    end else begin
      ack_reg  <= wb_req;
      rdat_reg <= rd_mux;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      mode_reg   <= `MODE_RESET;
      txsdll_reg <= `TXSDLL_DEF;
    end else begin
      if (wb_wr && sel_mode && i_wb_sel[0] && mode_wr_ok) begin
        mode_reg <= i_wb_dat[7:0];
      end
      if (wb_wr && sel_timing && i_wb_sel[0]) begin
        txsdll_reg[7:0] <= i_wb_dat[7:0];
      end
      if (wb_wr && sel_timing && i_wb_sel[1]) begin
        txsdll_reg[15:8] <= i_wb_dat[15:8];
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_wb_ack          = ack_reg;
  assign o_wb_dat          = rdat_reg;
  assign o_in_self_refresh = st_self;
  assign o_int_clk_en      = !st_self;
  assign o_int_refresh     = ref_busy_reg;
  assign o_dll_enable      = dll_on && !st_self;
  assign o_dll_reset       = st_exit && dll_on && !done_dll;
  assign o_rtt_park_on     = park_on && !st_self;
  assign o_odt_enable      = !st_self && !(st_exit && !done_dll) && !st_nopwin;
  assign o_ok_fast         = st_idle || (st_exit && done_fast);
  assign o_ok_nodll        = st_idle || (st_exit && done_xs);
  assign o_ok_dll          = st_idle || (st_exit && done_dll && done_xs);
  assign o_proto_error     = err_reg;
endmodule : sr_ctrl

/* sr_ctrl_chk.sv */
// assertions on the self refresh control ports
// assumes a bind onto sr_ctrl, one clock domain
module sr_ctrl_chk (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_act_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic o_in_self_refresh,
  input wire logic o_int_clk_en,
  input wire logic o_int_refresh,
  input wire logic o_dll_enable,
  input wire logic o_rtt_park_on,
  input wire logic o_odt_enable,
  input wire logic o_ok_fast,
  input wire logic o_ok_nodll,
  input wire logic o_ok_dll
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] since_exit;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // ----------------------------------------
  // cycles since leaving self refresh
  // ----------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || o_in_self_refresh)
      since_exit <= 16'h0000;
    else if (since_exit != 16'hffff)
      since_exit <= since_exit + 16'h0001;
  end
  sequence s_entry;
    !o_in_self_refresh && o_ok_nodll && !i_cke && !i_cs_n && !i_ras_n && !i_cas_n && i_we_n && i_act_n;
  endsequence
  sequence s_exit;
    o_in_self_refresh && i_cke && i_cs_n;
  endsequence
  a_entry_decode: assert property (s_entry |=> o_in_self_refresh)
    else $error("entry command not taken");
  a_exit_seen: assert property (s_exit |=> !o_in_self_refresh)
    else $error("exit command not taken");
  a_pins_ignored: assert property (o_in_self_refresh && !i_cke |=> o_in_self_refresh)
    else $error("left self refresh with cke low");
  a_term_off: assert property (o_in_self_refresh |-> !o_odt_enable && !o_rtt_park_on)
    else $error("termination on in self refresh");
  a_dll_off: assert property (o_in_self_refresh |-> !o_dll_enable)
    else $error("dll on in self refresh");
  a_clk_gated: assert property (o_in_self_refresh |-> !o_int_clk_en)
    else $error("internal clock running in self refresh");
  a_first_refresh: assert property ($rose(o_in_self_refresh) |-> ##[0:2] o_int_refresh)
    else $error("no internal refresh within tcke");
  a_fast_wait: assert property ($rose(o_ok_fast) |-> since_exit inside {[57:63], [86:94]})
    else $error("fast class released at wrong time");
  a_nodll_wait: assert property ($rose(o_ok_nodll) |-> since_exit inside {[57:63], [86:94]})
    else $error("non dll class released at wrong time");
  a_class_order: assert property (o_ok_dll |-> o_ok_nodll && o_ok_fast)
    else $error("dll class released before others");
endmodule : sr_ctrl_chk

bind sr_ctrl sr_ctrl_chk i_chk (.i_ref_clk, .i_sys_rst, .i_cke, .i_cs_n, .i_act_n, .i_ras_n, .i_cas_n,
  .i_we_n, .o_in_self_refresh, .o_int_clk_en, .o_int_refresh, .o_dll_enable, .o_rtt_park_on,
  .o_odt_enable, .o_ok_fast, .o_ok_nodll, .o_ok_dll);

/* sr_host_model.sv */
// memory controller model driving the command pins
// assumes the bench calls one task at a time
module sr_host_model (
  input  wire logic i_ref_clk,
  output logic      o_cke,
  output logic      o_cs_n,
  output logic      o_act_n,
  output logic      o_ras_n,
  output logic      o_cas_n,
  output logic      o_we_n,
  output logic      o_odt
);
  timeunit 1ns;
  timeprecision 1ps;
  // pin order: cke, cs_n, act_n, ras_n, cas_n, we_n
  initial begin
    {o_cke, o_cs_n, o_act_n, o_ras_n, o_cas_n, o_we_n} = 6'h3f;
    o_odt = 1'b0;
  end
  task automatic put(input logic [5:0] p);
    @(posedge i_ref_clk);
    {o_cke, o_cs_n, o_act_n, o_ras_n, o_cas_n, o_we_n} <= p;
  endtask : put
  task automatic sre();
    put(6'h09);
    put(6'h1f);
  endtask : sre
  task automatic noise();
    put(6'h06);
    put(6'h09);
    put(6'h1f);
  endtask : noise
  task automatic srx(input logic nop);
    if (nop) begin
      repeat (4) put(6'h2f);
    end
    put(6'h3f);
  endtask : srx
  task automatic refr();
    put(6'h29);
    put(6'h3f);
  endtask : refr
endmodule : sr_host_model

/* sr_ctrl_bench.sv */
// self checking bench for sr_ctrl
// assumes sr_host_model on the pins and the bound checker
module sr_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_ref_clk, i_sys_rst, i_cke, i_cs_n, i_act_n, i_ras_n, i_cas_n, i_we_n, i_odt;
  logic        i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, o_in_self_refresh, o_int_clk_en;
  logic        o_int_refresh, o_dll_enable, o_dll_reset, o_rtt_park_on, o_odt_enable;
  logic        o_ok_fast, o_ok_nodll, o_ok_dll, o_proto_error;
  logic [1:0]  i_temp_zone;
  logic [3:0]  i_wb_sel;
  logic [7:0]  i_wb_adr;
  logic [31:0] i_wb_dat, o_wb_dat, q;
  int          n_errors, num_checks, nf, nn, nd;
  sr_ctrl i_dut (.i_ref_clk, .i_sys_rst, .i_cke, .i_cs_n, .i_act_n, .i_ras_n, .i_cas_n, .i_we_n, .i_odt,
    .i_temp_zone, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack,
    .o_in_self_refresh, .o_int_clk_en, .o_int_refresh, .o_dll_enable, .o_dll_reset, .o_rtt_park_on,
    .o_odt_enable, .o_ok_fast, .o_ok_nodll, .o_ok_dll, .o_proto_error);
  sr_host_model i_host (.i_ref_clk, .o_cke(i_cke), .o_cs_n(i_cs_n), .o_act_n(i_act_n), .o_ras_n(i_ras_n),
    .o_cas_n(i_cas_n), .o_we_n(i_we_n), .o_odt(i_odt));
  always #2 i_ref_clk = ~i_ref_clk;
  // ----------------------------------------
  // checks and bus access
  // ----------------------------------------
  task automatic summarize();
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic near(input int got, input int exp);
    num_checks++;
    if (got < exp - 2 || got > exp + 2) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : near
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_ref_clk);
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'b11, w, a, d};
    do begin
      @(posedge i_ref_clk);
      k++;
    end while (o_wb_ack !== 1'b1 && k < 50);
    q = o_wb_dat;
    {i_wb_cyc, i_wb_stb, i_wb_we} <= 3'b000;
    if (k >= 50) begin
      n_errors++;
      summarize();
    end
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask : rd
  task automatic xwait();
    nf = 0;
    nn = 0;
    nd = 0;
    for (int k = 1; k <= 1000 && nd == 0; k++) begin
      @(posedge i_ref_clk);
      if (k == 5)
        chk(32'({o_dll_reset, o_rtt_park_on, o_odt_enable}), 32'h6);
      if (nf == 0 && o_ok_fast === 1'b1) nf = k;
      if (nn == 0 && o_ok_nodll === 1'b1) nn = k;
      if (o_ok_dll === 1'b1) nd = k;
    end
    if (nd == 0) begin
      n_errors++;
      summarize();
    end
  endtask : xwait
  task automatic sr_run(input logic [31:0] m, input logic nop, input int ef, input int en, input int ed);
    int k;
    wb(1'b1, 8'h00, m);
    i_host.sre();
    @(posedge i_ref_clk);
    chk(32'({o_in_self_refresh, o_odt_enable, o_rtt_park_on, o_dll_enable, o_int_clk_en, o_ok_fast}), 32'h20);
    for (k = 0; k < 4 && o_int_refresh !== 1'b1; k++) @(posedge i_ref_clk);
    chk(32'(o_int_refresh), 32'h1);
    i_host.noise();
    wb(1'b1, 8'h00, m ^ 32'h1);
    rd(8'h00, 32'hff, (m[1:0] == 2'b11) ? (m ^ 32'h1) : m);
    chk(32'(o_in_self_refresh), 32'h1);
    repeat (20) @(posedge i_ref_clk);
    i_host.srx(nop);
    xwait();
    near(nf, ef);
    near(nn, en);
    near(nd, ed);
    chk(32'(o_proto_error), 32'h0);
    i_host.refr();
  endtask : sr_run
  initial begin
    repeat (100000) @(posedge i_ref_clk);
    n_errors++;
    summarize();
  end
  initial begin
    i_ref_clk = 1'b0;
    i_sys_rst = 1'b1;
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} = '0;
    i_wb_sel = 4'hf;
    i_temp_zone = 2'h1;
    repeat (6) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    rd(8'h00, 32'hff, 32'h08);
    rd(8'h0c, 32'hffffffff, 32'h0);
    wb(1'b1, 8'h10, 32'hffffffff);
    rd(8'h10, 32'hffffffff, 32'h0);
    wb(1'b1, 8'h08, 32'h00c8);
    rd(8'h08, 32'hffff, 32'h00c8);
    for (int r = 0; r < 4; r++) begin
      wb(1'b1, 8'h00, 32'h18 | 32'(r));
      rd(8'h00, 32'hff, 32'h18 | 32'(r));
    end
    sr_run(32'h18, 1'b0, 61, 91, 201);
    sr_run(32'h1c, 1'b0, 61, 61, 201);
    i_temp_zone <= 2'h3;
    sr_run(32'h1b, 1'b0, 61, 91, 201);
    sr_run(32'h18, 1'b1, 88, 88, 198);
    i_host.sre();
    repeat (20) @(posedge i_ref_clk);
    i_host.srx(1'b0);
    i_host.refr();
    repeat (2) @(posedge i_ref_clk);
    chk(32'(o_proto_error), 32'h1);
    rd(8'h04, 32'h100, 32'h100);
    wb(1'b1, 8'h04, 32'h100);
    rd(8'h04, 32'h100, 32'h0);
    summarize();
  end
endmodule : sr_ctrl_bench
